// ---- snc_buf.sv ----
// Two-entry valid/ready buffer for checksum results
module snc_buf (
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_in,
    input  wire logic                 in_valid_in,
    output logic                      in_ready_out,
    input  wire snc_pkg::snc_result_t in_data_in,
    output logic                      out_valid_out,
    input  wire logic                 out_ready_in,
    output snc_pkg::snc_result_t      out_data_out
);
    snc_pkg::snc_result_t mem_reg [snc_pkg::BUF_DEPTH];
    logic       wr_ptr_reg;
    logic       rd_ptr_reg;
    logic [1:0] count_reg;
    logic       push;
    logic       pop;

    assign in_ready_out  = (count_reg != 2'h2);
    assign out_valid_out = (count_reg != 2'h0);
    assign out_data_out  = mem_reg[rd_ptr_reg];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;

    always_ff @(posedge sys_clk_in)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
            begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
        end
    end

    chk_buf_no_overflow: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        count_reg <= 2'h2)
        else $error("Result buffer count above two");
endmodule

// ---- snc_crc4.sv ----
// Nibble checksum engine: folds status and data nibbles, checks the checksum
// Operation
// - Checksum is 4-bit CRC over status nibble then data nibbles only
// - Generator polynomial x^4+x^3+x^2+1 on a 4-bit remainder
// - Remainder loaded with seed 0101 before the frame's first nibble
// - Per nibble: xor into remainder, then replace by table entry
// - Table holds 0,13,7,10,14,3,9,4,1,12,6,11,15,2,8,5
// - Bit-serial xor/shift form must give the same remainder
// - Format 0/1/2/3 selects 6/4/5/3 data nibbles
module snc_crc4 (
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_in,
    input  wire logic [1:0]           frame_fmt_in,
    input  wire logic                 nib_valid_in,
    output logic                      nib_ready_out,
    input  wire snc_pkg::snc_nib_t    nib_in,
    output logic                      res_valid_out,
    input  wire logic                 res_ready_in,
    output snc_pkg::snc_result_t      res_out,
    output logic [3:0]                crc_out,
    output logic                      crc_err_out
);
    // Entries of the nibble table, index 0 at the low end
    localparam logic [63:0] NIBBLE_CRC_TABLE = 64'h582fb6c1493ea7d0;

    snc_pkg::snc_state_t state_reg;
    logic [3:0] rem_reg;
    logic [3:0] rem_next;
    logic [3:0] rem_base;
    logic [2:0] nib_cnt_reg;
    logic [2:0] nib_total;
    logic [1:0] fmt_reg;
    logic [3:0] crc_reg;
    logic       crc_err_reg;
    logic       res_push;
    logic       buf_ready;
    logic       take;
    snc_pkg::snc_result_t res_word;

    function automatic logic [3:0] nibble_crc_table(input logic [3:0] idx);
        nibble_crc_table = NIBBLE_CRC_TABLE[idx*4 +: 4];
    endfunction

    // Bit-serial reference, used only to cross-check the table
    function automatic logic [3:0] serial_fold(input logic [3:0] r, input logic [3:0] n);
        logic [3:0] s;
        s = r ^ n;
        for (int b = 0; b < 4; b++)
        begin
            s = s[3] ? ({s[2:0], 1'b0} ^ 4'hd) : {s[2:0], 1'b0};
        end
        serial_fold = s;
    endfunction

    always_comb
    begin
        case (fmt_reg)
            2'h0: nib_total = snc_pkg::NIBS_FMT0;
            2'h1: nib_total = snc_pkg::NIBS_FMT1;
            2'h2: nib_total = snc_pkg::NIBS_FMT2;
            default: nib_total = snc_pkg::NIBS_FMT3;
        endcase
    end

    // Checking stalls while the result buffer is full
    assign nib_ready_out = (state_reg != snc_pkg::ST_CHECK) || buf_ready;
    assign take = nib_valid_in && nib_ready_out;
    assign rem_base = nib_in.first ? snc_pkg::CRC_SEED : rem_reg;
    assign rem_next = nibble_crc_table(rem_base ^ nib_in.nibble);

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            state_reg   <= snc_pkg::ST_IDLE;
            rem_reg     <= snc_pkg::CRC_SEED;
            nib_cnt_reg <= snc_pkg::NIB_CNT_RESET;
            fmt_reg     <= snc_pkg::FMT_RESET;
        end
        else if (take)
        begin
            // A first marker always restarts the frame, resyncing after errors
            if (nib_in.first)
            begin
                fmt_reg     <= frame_fmt_in;
                rem_reg     <= rem_next;
                nib_cnt_reg <= snc_pkg::NIB_CNT_RESET;
                state_reg   <= snc_pkg::ST_FOLD;
            end
            else
            begin
                case (state_reg)
                    snc_pkg::ST_FOLD:
                    begin
                        rem_reg     <= rem_next;
                        nib_cnt_reg <= 3'(nib_cnt_reg + 3'h1);
                        if (3'(nib_cnt_reg + 3'h1) == nib_total)
                        begin
                            state_reg <= snc_pkg::ST_CHECK;
                        end
                    end
                    snc_pkg::ST_CHECK:
                    begin
                        rem_reg   <= snc_pkg::CRC_SEED;
                        state_reg <= snc_pkg::ST_IDLE;
                    end
                    default:
                    begin
                        state_reg <= snc_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign res_push = take && !nib_in.first && (state_reg == snc_pkg::ST_CHECK);
    assign res_word = '{
        crc:      rem_reg,
        received: nib_in.nibble,
        crc_ok:   (rem_reg == nib_in.nibble),
        checked:  1'b1
    };

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            crc_reg     <= snc_pkg::CRC_SEED;
            crc_err_reg <= 1'b0;
        end
        else if (res_push)
        begin
            crc_reg     <= rem_reg;
            crc_err_reg <= (rem_reg != nib_in.nibble);
        end
    end

    assign crc_out     = crc_reg;
    assign crc_err_out = crc_err_reg;

    snc_buf u_buf (
        .sys_clk_in    (sys_clk_in),
        .reset_in      (reset_in),
        .in_valid_in   (res_push),
        .in_ready_out  (buf_ready),
        .in_data_in    (res_word),
        .out_valid_out (res_valid_out),
        .out_ready_in  (res_ready_in),
        .out_data_out  (res_out)
    );

    sequence s_first_taken;
        take && nib_in.first;
    endsequence

    chk_seed_load: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_first_taken |=> rem_reg == nibble_crc_table(snc_pkg::CRC_SEED ^ $past(nib_in.nibble)))
        else $error("First nibble not folded from seed");
    chk_serial_match: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        take |-> rem_next == serial_fold(rem_base, nib_in.nibble))
        else $error("Table and serial fold disagree");
    chk_fold_update: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        take && (state_reg == snc_pkg::ST_FOLD) && !nib_in.first
        |=> rem_reg == nibble_crc_table($past(rem_reg) ^ $past(nib_in.nibble)))
        else $error("Remainder not updated from table");
    chk_table_entry: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        nibble_crc_table(4'h1) == 4'hd && nibble_crc_table(4'hf) == 4'h5)
        else $error("Table entry wrong");
    chk_frame_len: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (state_reg == snc_pkg::ST_CHECK) |-> nib_cnt_reg == nib_total)
        else $error("Check reached with wrong nibble count");
    chk_err_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        res_push |=> crc_err_out == ($past(rem_reg) != $past(nib_in.nibble)))
        else $error("Checksum error flag wrong");
    chk_poly_step: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        serial_fold(4'h0, 4'h1) == 4'hd)
        else $error("Polynomial step wrong");
    chk_check_leaves: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        res_push |=> state_reg == snc_pkg::ST_IDLE && rem_reg == snc_pkg::CRC_SEED)
        else $error("Check did not end the frame");
    chk_fold_only: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (state_reg == snc_pkg::ST_IDLE) && !(take && nib_in.first) |=> $stable(rem_reg))
        else $error("Remainder changed outside a frame");

    // Frame restart, nibble count, check outcome capture and hand-off
    sequence s_check_taken;
        take && !nib_in.first && (state_reg == snc_pkg::ST_CHECK);
    endsequence

    sequence s_data_taken;
        take && !nib_in.first && (state_reg == snc_pkg::ST_FOLD);
    endsequence

    chk_fmt_latch: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_first_taken |=> fmt_reg == $past(frame_fmt_in))
        else $error("Frame format not latched with status nibble");
    chk_frame_restart: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_first_taken
        |=> state_reg == snc_pkg::ST_FOLD && nib_cnt_reg == snc_pkg::NIB_CNT_RESET)
        else $error("Status nibble did not restart the frame");
    chk_count_step: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_data_taken |=> nib_cnt_reg == 3'($past(nib_cnt_reg) + 3'h1))
        else $error("Data nibble count did not advance");
    chk_crc_capture: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_check_taken |=> crc_out == $past(rem_reg))
        else $error("Checksum output not captured at check");
    chk_crc_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !res_push |=> $stable(crc_out) && $stable(crc_err_out))
        else $error("Checksum output changed without a check");
    chk_result_queued: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_check_taken |=> res_valid_out)
        else $error("Check result not offered");
    chk_ok_flag_agree: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_check_taken |=> crc_err_out != $past(res_word.crc_ok))
        else $error("Result word and error flag disagree");
    chk_idle_stays: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (state_reg == snc_pkg::ST_IDLE) && take && !nib_in.first
        |=> state_reg == snc_pkg::ST_IDLE)
        else $error("Stray nibble left idle state");
endmodule

// ---- snc_crc4_test.sv ----
// Self-checking bench for the nibble checksum engine
module snc_crc4_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 sys_clk_in = 1'b0;
    logic                 reset_in = 1'b1;
    logic [1:0]           frame_fmt_in = 2'h0;
    logic                 nib_valid_in = 1'b0;
    logic                 nib_ready_out;
    snc_pkg::snc_nib_t    nib_in = '0;
    logic                 res_valid_out;
    logic                 res_ready_in;
    snc_pkg::snc_result_t res_out;
    logic [3:0]           crc_out;
    logic                 crc_err_out;
    logic                 stall = 1'b0;
    int                   err_count = 0;
    int                   compares = 0;
    snc_pkg::snc_result_t exp_q[$];
    logic [3:0]           tbl [16] = '{4'h0, 4'hd, 4'h7, 4'ha, 4'he, 4'h3, 4'h9, 4'h4,
                                       4'h1, 4'hc, 4'h6, 4'hb, 4'hf, 4'h2, 4'h8, 4'h5};

    always #10 sys_clk_in = ~sys_clk_in;

    snc_crc4 i_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .frame_fmt_in(frame_fmt_in),
        .nib_valid_in(nib_valid_in), .nib_ready_out(nib_ready_out), .nib_in(nib_in),
        .res_valid_out(res_valid_out), .res_ready_in(res_ready_in), .res_out(res_out),
        .crc_out(crc_out), .crc_err_out(crc_err_out));
    snc_rx_model i_rx (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .stall_in(stall),
        .res_valid_in(res_valid_out), .res_ready_out(res_ready_in), .res_in(res_out));

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        compares++;
        if (seen !== want)
        begin
            err_count++;
            $display("FAIL %0t saw %h expected %h", $time, seen, want);
        end
    endtask

    // Leaves valid high so back-to-back nibbles need no extra cycle
    task automatic send_nib(input logic f, input logic [3:0] n);
        int i;
        nib_valid_in = 1'b1;
        nib_in = '{first: f, nibble: n};
        for (i = 0; i < 50 && nib_ready_out !== 1'b1; i++)
            @(negedge sys_clk_in);
        if (i == 50)
        begin
            err_count++;
            print_verdict();
        end
        @(negedge sys_clk_in);
    endtask

    task automatic send_frame(input logic [1:0] fmt, input logic [3:0] st, input logic bad,
                              input logic chk);
        logic [3:0] r;
        logic [3:0] d;
        int         n;
        int         k;
        n = fmt[0] ? (fmt[1] ? 3 : 4) : (fmt[1] ? 5 : 6);
        frame_fmt_in = fmt;
        r = tbl[4'h5 ^ st];
        send_nib(1'b1, st);
        frame_fmt_in = ~fmt;
        for (k = 0; k < n; k++)
        begin
            d = 4'(st + 3 * k + 1);
            r = tbl[r ^ d];
            send_nib(1'b0, d);
        end
        d = r ^ {3'h0, bad};
        exp_q.push_back('{r, d, !bad, 1'b1});
        send_nib(1'b0, d);
        nib_valid_in = 1'b0;
        // Let an edge pass so the next frame never re-raises valid in this step
        @(negedge sys_clk_in);
        if (chk)
        begin
            check({6'h0, crc_out}, {6'h0, r});
            check({9'h0, crc_err_out}, {9'h0, bad});
        end
    endtask

    task automatic drain();
        int i;
        for (i = 0; i < 20 && i_rx.got_q.size() < exp_q.size(); i++)
            @(negedge sys_clk_in);
        check(10'(i_rx.got_q.size()), 10'(exp_q.size()));
        while (exp_q.size() > 0 && i_rx.got_q.size() > 0)
            check(i_rx.got_q.pop_front(), exp_q.pop_front());
    endtask

    task automatic test_formats();
        for (int f = 0; f < 4; f++)
            send_frame(2'(f), 4'(4 * f + 2), 1'b0, 1'b1);
        send_frame(2'h0, 4'hc, 1'b1, 1'b1);
        send_frame(2'h2, 4'hf, 1'b0, 1'b1);
        drain();
    endtask

    // Stray data while idle and a restarted frame must give no result
    task automatic test_abort();
        send_nib(1'b0, 4'h9);
        send_nib(1'b1, 4'h2);
        send_nib(1'b0, 4'h7);
        send_frame(2'h1, 4'h0, 1'b0, 1'b1);
        drain();
    endtask

    task automatic test_stall();
        stall = 1'b1;
        send_frame(2'h1, 4'h3, 1'b0, 1'b1);
        send_frame(2'h3, 4'ha, 1'b1, 1'b0);
        fork
            send_frame(2'h3, 4'h6, 1'b0, 1'b0);
            begin
                repeat (12) @(negedge sys_clk_in);
                check({9'h0, nib_ready_out}, 10'h0);
                check({9'h0, res_valid_out}, 10'h1);
                stall = 1'b0;
            end
        join
        drain();
    endtask

    initial
    begin
        repeat (8) @(negedge sys_clk_in);
        reset_in = 1'b0;
        check({6'h0, crc_out}, 10'h5);
        check({7'h0, res_valid_out, nib_ready_out, crc_err_out}, 10'h2);
        test_formats();
        test_abort();
        test_stall();
        print_verdict();
    end
endmodule

// ---- snc_pkg.sv ----
// Package for the nibble checksum block: constants and carrier types
package snc_pkg;

    localparam int unsigned NIBBLE_W      = 4;
    localparam logic [3:0]  CRC_SEED      = 4'h5;
    localparam logic [1:0]  FMT_RESET     = 2'h0;
    localparam logic [2:0]  NIB_CNT_RESET = 3'h0;
    localparam logic [2:0]  NIBS_FMT0     = 3'h6;
    localparam logic [2:0]  NIBS_FMT1     = 3'h4;
    localparam logic [2:0]  NIBS_FMT2     = 3'h5;
    localparam logic [2:0]  NIBS_FMT3     = 3'h3;
    localparam int unsigned BUF_DEPTH     = 2;

    // Input word: one nibble of the frame with its first-nibble marker
    typedef struct packed {
        logic       first;
        logic [3:0] nibble;
    } snc_nib_t;

    // Result word: computed checksum and compare outcome
    typedef struct packed {
        logic [3:0] crc;
        logic [3:0] received;
        logic       crc_ok;
        logic       checked;
    } snc_result_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FOLD  = 3'b010,
        ST_CHECK = 3'b100
    } snc_state_t;

endpackage

// ---- snc_rx_model.sv ----
// Result consumer standing in for the receiving controller
module snc_rx_model (
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_in,
    input  wire logic                 stall_in,
    input  wire logic                 res_valid_in,
    output logic                      res_ready_out,
    input  wire snc_pkg::snc_result_t res_in
);
    snc_pkg::snc_result_t got_q[$];

    // Stall comes from the bench so the buffer can be filled on purpose
    assign res_ready_out = !stall_in;

    // Outcome kept with each word so error frames never pass as good data
    always @(posedge sys_clk_in)
    begin
        if (!reset_in && res_valid_in && res_ready_out)
            got_q.push_back(res_in);
    end
endmodule
